// file: mmio_pkg.sv
// Purpose: Shared constants and types for the multi-mode I/O port block.
// Assumes: CPU special-function-register bus, 8-bit data, one clock domain.
// Notes:   Pin vector order is Port1[7:0], Port2[1:0], Port3[7:0] (index 0..17).
// How it works
// - Modes zero to two: pullup, Hi-Z, push-pull
// - Mode three: analog input, digital buffer off
// - LED, converter, touch functions use mode three
// - Read-modify-write reads latch, not pin level
// - Pseudo open drain kicks high briefly, then keeps
// - LED/LCD function overrides every other pin use
// - Timer and clock outputs ignore the latch
// - Pulse outputs ignore the latch value
// - SPI pins driven or taken by role
// - Serial pins pseudo open drain; second true open
// - Crystal select bits turn Port2 pins oscillator
package mmio_pkg;

    // ==========================================================
    // Register offsets on the SFR bus
    localparam logic [7:0] ADDR_P1_LATCH   = 8'h90;
    localparam logic [7:0] ADDR_P2_MODES   = 8'h93;
    localparam logic [7:0] ADDR_P2_LATCH   = 8'hA0;
    localparam logic [7:0] ADDR_P1_MODES_L = 8'hA2;
    localparam logic [7:0] ADDR_P1_MODES_H = 8'hA3;
    localparam logic [7:0] ADDR_P3_MODES_L = 8'hA4;
    localparam logic [7:0] ADDR_P3_MODES_H = 8'hA5;
    localparam logic [7:0] ADDR_P3_LATCH   = 8'hB0;
    localparam logic [7:0] ADDR_CLK_CTRL   = 8'hD8;

    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_P1_LATCH   = 8'hFF;
    localparam logic [7:0] RST_P2_LATCH   = 8'h03;
    localparam logic [7:0] RST_P3_LATCH   = 8'hFF;
    localparam logic [7:0] RST_MODES      = 8'h55;
    localparam logic [7:0] RST_P2_MODES   = 8'h05;
    localparam logic [7:0] RST_P3_MODES_H = 8'h15;
    localparam logic [7:0] RST_CLK_CTRL   = 8'h23;

    // ==========================================================
    // Field positions
    localparam int SLOW_XTAL_BIT  = 7;   // slow_crystal_select in clock_control
    localparam int FAST_XTAL_BIT  = 6;   // fast_crystal_select in clock_control
    localparam int PINOUT_CKO_BIT = 5;   // pin_output_control: clock half out
    localparam int PINOUT_T2O_BIT = 4;   // pin_output_control: timer two out
    localparam int PINOUT_T0O_BIT = 0;   // pin_output_control: timer zero out
    localparam int SPI_EN_BIT     = 7;   // serial_periph_control enable
    localparam int SPI_MSTR_BIT   = 6;   // serial_periph_control master
    localparam int P2_MODE_BITS   = 4;   // used width of Port2 mode register

    // ==========================================================
    // Pin indices in the 18-bit pin vector
    localparam int NUM_PINS    = 18;
    localparam int PIN_T2O     = 0;      // P1.0
    localparam int PIN_PWM0    = 2;      // P1.2
    localparam int PIN_PWM1    = 3;      // P1.3
    localparam int PIN_CKO     = 4;      // P1.4
    localparam int PIN_PWM2    = 6;      // P1.6
    localparam int PIN_MISO    = 7;      // P1.7, also second serial transmit
    localparam int PIN_OSC_IN  = 8;      // P2.0
    localparam int PIN_OSC_OUT = 9;      // P2.1
    localparam int PIN_TXD     = 11;     // P3.1
    localparam int PIN_T0O     = 14;     // P3.4
    localparam int PIN_MOSI    = 15;     // P3.5
    localparam int PIN_SCK     = 16;     // P3.6

    // Pins with converter inputs: P1.0..P1.5 and P3.0..P3.3
    localparam logic [17:0] ANALOG_PINS = 18'h03C3F;
    // Pseudo-open-drain pins: P3.0..P3.2
    localparam logic [17:0] PSEUDO_PINS = 18'h01C00;

    // ==========================================================
    // Timing: strong high kick after a rising edge
    localparam int KICK_NS     = 20;
    localparam int CLK_NS      = 10;
    localparam int KICK_CYCLES = (KICK_NS / CLK_NS < 1) ? 1 : KICK_NS / CLK_NS;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        MMIO_MODE_PULLUP = 2'b00,        // Open drain with pull-up
        MMIO_MODE_OPEN   = 2'b01,        // Open drain, Hi-Z for one
        MMIO_MODE_PUSH   = 2'b10,        // Push-pull
        MMIO_MODE_ANALOG = 2'b11         // Analog, digital buffer off
    } mmio_mode_t;

    // Outputs of peripherals that can own a pin
    typedef struct packed {
        logic       t0_ovf;              // timer_zero_overflow_out
        logic       t2_ovf;              // timer_two_overflow_out
        logic       clk_half;            // sysclk_half_out
        logic [2:0] pwm;                 // pulse outputs 2..0
        logic       txd;                 // primary serial transmit
        logic       second_serial_transmit;                // second_serial_transmit
        logic       sck;                 // SPI clock when master
        logic       mosi;                // SPI data out when master
        logic       miso;                // SPI data out when slave
    } mmio_alt_t;

    // LED/LCD driver claim on the pins
    typedef struct packed {
        logic [17:0] active;             // Pin owned by LED/LCD logic
        logic [17:0] value;              // Level to drive
        logic [17:0] drive;              // Strong drive wanted
    } mmio_led_t;

endpackage

// file: mmio_port.sv
// Purpose: Port1/2/3 pin control: latches, mode fields, drivers, input sampling.
// Assumes: Single 100 MHz clock, synchronous active-high reset, SFR bus access.
// Notes:   Read data and all pin controls are registered, one cycle behind.
`timescale 1ns/1ps
module mmio_port #(
    parameter int KICK = mmio_pkg::KICK_CYCLES
) (
    // Clock and reset
    input  wire logic                   core_clk_in,
    input  wire logic                   reset_in,
    // SFR bus from the CPU core
    input  wire logic [7:0]             sfr_addr_in,
    input  wire logic                   sfr_wr_in,
    input  wire logic                   sfr_rd_in,
    input  wire logic                   sfr_rmw_in,
    input  wire logic [7:0]             sfr_wdata_in,
    output logic      [7:0]             sfr_rdata_out,
    output logic                        sfr_hit_out,
    // Controls held by neighbouring peripherals
    input  wire logic [7:0]             pin_output_control_in,
    input  wire logic [2:0]             pulse_output_enable_in,
    input  wire logic [7:0]             serial_periph_control_in,
    input  wire mmio_pkg::mmio_alt_t    alt_in,
    input  wire mmio_pkg::mmio_led_t    led_in,
    // Pins
    input  wire logic [17:0]            pin_in,
    output logic      [17:0]            pin_out,
    output logic      [17:0]            pin_oe_n_out,
    output logic      [17:0]            pin_pullup_out,
    output logic      [17:0]            pin_analog_out,
    // Toward peripherals and clock block
    output logic      [17:0]            pin_level_out,
    output logic      [7:0]             clock_control_out,
    output logic                        xtal_enable_out
);

    // ==========================================================
    // Register state
    logic [7:0]  p1_latch_r;             // port1_data_latch
    logic [7:0]  p2_latch_r;             // port2_data_latch
    logic [7:0]  p3_latch_r;             // Port3 data latch
    logic [7:0]  p1_mode_l_r;            // port1_low_pin_modes
    logic [7:0]  p1_mode_h_r;            // port1_high_pin_modes
    logic [3:0]  p2_mode_r;              // Port2 pin modes
    logic [7:0]  p3_mode_l_r;            // Port3 low pin modes
    logic [7:0]  p3_mode_h_r;            // Port3 high pin modes
    logic [7:0]  clk_ctrl_r;             // clock_control

    // Pin input sampling
    logic [17:0] sync1_r;                // First sampling stage
    logic [17:0] sync2_r;                // Second stage
    logic [17:0] sync3_r;                // Third stage
    logic [17:0] level_r;                // Accepted level

    // Kick timing
    logic [17:0] data_prev_r;            // Effective data last cycle
    logic [1:0]  kick_cnt_r [18];        // Strong-high cycles left

    // Combinational pin plan
    logic [17:0] data_nxt;               // Effective output data
    logic [17:0] out_nxt;
    logic [17:0] oe_n_nxt;
    logic [17:0] pu_nxt;
    logic [17:0] din_en_nxt;
    logic [17:0] ana_nxt;
    logic [17:0] forced;                 // Peripheral owns data, latch ignored
    logic [17:0] alt_val;                // Peripheral data per pin
    logic [35:0] modes;                  // Two bits per pin
    logic        xtal_on;                // Either crystal select set
    logic [17:0] latches;                // Latch bit per pin

    // ==========================================================
    // Mode of one pin from the packed mode vector
    function automatic mmio_pkg::mmio_mode_t mode_of(input logic [35:0] m, input int i);
        return mmio_pkg::mmio_mode_t'(m[2*i +: 2]);
    endfunction

    assign modes   = {p3_mode_h_r, p3_mode_l_r, p2_mode_r, p1_mode_h_r, p1_mode_l_r};
    assign latches = {p3_latch_r, p2_latch_r[1:0], p1_latch_r};
    assign xtal_on = clk_ctrl_r[mmio_pkg::SLOW_XTAL_BIT]
                   | clk_ctrl_r[mmio_pkg::FAST_XTAL_BIT];

    // ==========================================================
    // SFR writes; reset restores documented values
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            p1_latch_r  <= mmio_pkg::RST_P1_LATCH;
            p2_latch_r  <= mmio_pkg::RST_P2_LATCH;
            p3_latch_r  <= mmio_pkg::RST_P3_LATCH;
            p1_mode_l_r <= mmio_pkg::RST_MODES;
            p1_mode_h_r <= mmio_pkg::RST_MODES;
            p2_mode_r   <= mmio_pkg::RST_P2_MODES[3:0];
            p3_mode_l_r <= mmio_pkg::RST_MODES;
            p3_mode_h_r <= mmio_pkg::RST_P3_MODES_H;
            clk_ctrl_r  <= mmio_pkg::RST_CLK_CTRL;
        end else if (sfr_wr_in) begin
            case (sfr_addr_in)
                mmio_pkg::ADDR_P1_LATCH:   p1_latch_r  <= sfr_wdata_in;
                mmio_pkg::ADDR_P2_LATCH:   p2_latch_r  <= sfr_wdata_in;
                mmio_pkg::ADDR_P3_LATCH:   p3_latch_r  <= sfr_wdata_in;
                mmio_pkg::ADDR_P1_MODES_L: p1_mode_l_r <= sfr_wdata_in;
                mmio_pkg::ADDR_P1_MODES_H: p1_mode_h_r <= sfr_wdata_in;
                mmio_pkg::ADDR_P2_MODES:   p2_mode_r   <= sfr_wdata_in[3:0];
                mmio_pkg::ADDR_P3_MODES_L: p3_mode_l_r <= sfr_wdata_in;
                mmio_pkg::ADDR_P3_MODES_H: p3_mode_h_r <= sfr_wdata_in;
                mmio_pkg::ADDR_CLK_CTRL:   clk_ctrl_r  <= sfr_wdata_in;
                default: begin
                    // Not ours: another block answers
                end
            endcase
        end
    end

    // ==========================================================
    // SFR reads. A read-modify-write read returns the latch so that
    // bits held low by the board are not written back as zero.
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            sfr_rdata_out <= 8'h00;
            sfr_hit_out   <= 1'b0;
        end else begin
            sfr_hit_out <= sfr_rd_in;
            case (sfr_addr_in)
                mmio_pkg::ADDR_P1_LATCH: begin
                    sfr_rdata_out <= sfr_rmw_in ? p1_latch_r : level_r[7:0];
                end
                mmio_pkg::ADDR_P2_LATCH: begin
                    // Bits above P2.1 have no pin and read back the latch
                    sfr_rdata_out <= sfr_rmw_in ? p2_latch_r
                                   : {p2_latch_r[7:2], level_r[9:8]};
                end
                mmio_pkg::ADDR_P3_LATCH: begin
                    sfr_rdata_out <= sfr_rmw_in ? p3_latch_r : level_r[17:10];
                end
                mmio_pkg::ADDR_P1_MODES_L: sfr_rdata_out <= p1_mode_l_r;
                mmio_pkg::ADDR_P1_MODES_H: sfr_rdata_out <= p1_mode_h_r;
                mmio_pkg::ADDR_P2_MODES:   sfr_rdata_out <= {4'h0, p2_mode_r};
                mmio_pkg::ADDR_P3_MODES_L: sfr_rdata_out <= p3_mode_l_r;
                mmio_pkg::ADDR_P3_MODES_H: sfr_rdata_out <= p3_mode_h_r;
                mmio_pkg::ADDR_CLK_CTRL:   sfr_rdata_out <= clk_ctrl_r;
                default: begin
                    sfr_rdata_out <= 8'h00;
                    sfr_hit_out   <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // Peripheral ownership of pins, independent of the latch
    always_comb begin
        forced  = '0;
        alt_val = '0;
        // Timer and clock outputs enabled by the pin output control
        forced[mmio_pkg::PIN_T0O]  = pin_output_control_in[mmio_pkg::PINOUT_T0O_BIT];
        alt_val[mmio_pkg::PIN_T0O] = alt_in.t0_ovf;
        forced[mmio_pkg::PIN_T2O]  = pin_output_control_in[mmio_pkg::PINOUT_T2O_BIT];
        alt_val[mmio_pkg::PIN_T2O] = alt_in.t2_ovf;
        forced[mmio_pkg::PIN_CKO]  = pin_output_control_in[mmio_pkg::PINOUT_CKO_BIT];
        alt_val[mmio_pkg::PIN_CKO] = alt_in.clk_half;
        // Pulse outputs
        forced[mmio_pkg::PIN_PWM0]  = pulse_output_enable_in[0];
        alt_val[mmio_pkg::PIN_PWM0] = alt_in.pwm[0];
        forced[mmio_pkg::PIN_PWM1]  = pulse_output_enable_in[1];
        alt_val[mmio_pkg::PIN_PWM1] = alt_in.pwm[1];
        forced[mmio_pkg::PIN_PWM2]  = pulse_output_enable_in[2];
        alt_val[mmio_pkg::PIN_PWM2] = alt_in.pwm[2];
        // SPI outputs by role; inputs need no ownership
        if (serial_periph_control_in[mmio_pkg::SPI_EN_BIT]) begin
            if (serial_periph_control_in[mmio_pkg::SPI_MSTR_BIT]) begin
                forced[mmio_pkg::PIN_SCK]   = 1'b1;
                alt_val[mmio_pkg::PIN_SCK]  = alt_in.sck;
                forced[mmio_pkg::PIN_MOSI]  = 1'b1;
                alt_val[mmio_pkg::PIN_MOSI] = alt_in.mosi;
            end else begin
                forced[mmio_pkg::PIN_MISO]  = 1'b1;
                alt_val[mmio_pkg::PIN_MISO] = alt_in.miso;
            end
        end
    end

    // ==========================================================
    // Effective data: owned pins follow the peripheral; serial
    // transmitters combine with the latch as on a classic port
    always_comb begin
        data_nxt = (forced & alt_val) | (~forced & latches);
        if (!forced[mmio_pkg::PIN_TXD]) begin
            data_nxt[mmio_pkg::PIN_TXD] = latches[mmio_pkg::PIN_TXD] & alt_in.txd;
        end
        if (!forced[mmio_pkg::PIN_MISO]) begin
            data_nxt[mmio_pkg::PIN_MISO] = latches[mmio_pkg::PIN_MISO] & alt_in.second_serial_transmit;
        end
    end

    // ==========================================================
    // Per-pin driver plan from mode, data and overrides
    always_comb begin
        for (int i = 0; i < mmio_pkg::NUM_PINS; i++) begin
            out_nxt[i]    = data_nxt[i];
            oe_n_nxt[i]   = 1'b1;
            pu_nxt[i]     = 1'b0;
            din_en_nxt[i] = 1'b0;
            ana_nxt[i]    = 1'b0;
            if (led_in.active[i]) begin
                // LED/LCD owns the pin over everything else
                out_nxt[i]    = led_in.value[i];
                oe_n_nxt[i]   = ~led_in.drive[i];
            end else if (xtal_on && (i == mmio_pkg::PIN_OSC_IN || i == mmio_pkg::PIN_OSC_OUT)) begin
                // Oscillator pins: output and pull-up off; input still sampled unless the pin is in mode three
                out_nxt[i] = 1'b0;
            end else begin
                case (mode_of(modes, i))
                    mmio_pkg::MMIO_MODE_PUSH: begin
                        oe_n_nxt[i] = 1'b0;
                    end
                    mmio_pkg::MMIO_MODE_ANALOG: begin
                        // Latch ignored, no pull-up, converter path only
                        out_nxt[i] = 1'b0;
                        ana_nxt[i] = mmio_pkg::ANALOG_PINS[i];
                    end
                    mmio_pkg::MMIO_MODE_PULLUP,
                    mmio_pkg::MMIO_MODE_OPEN: begin
                        if (!data_nxt[i]) begin
                            oe_n_nxt[i] = 1'b0;
                        end else if (mmio_pkg::PSEUDO_PINS[i]
                            && (!data_prev_r[i] || kick_cnt_r[i] != 2'h0)) begin
                            oe_n_nxt[i]   = 1'b0;
                            din_en_nxt[i] = 1'b1;
                        end else begin
                            // Weak keeper in mode 0 or on P3.0..P3.2, released otherwise in mode 1
                            pu_nxt[i] = (mode_of(modes, i) == mmio_pkg::MMIO_MODE_PULLUP)
                                      | mmio_pkg::PSEUDO_PINS[i];
                            din_en_nxt[i] = 1'b1;
                        end
                    end
                    default: begin
                        oe_n_nxt[i] = 1'b1;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Strong-high kick counter: armed on a rising data edge, then
    // counts down so the strong drive lasts a bounded time
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            data_prev_r <= 18'h3FFFF;
            for (int i = 0; i < mmio_pkg::NUM_PINS; i++) begin
                kick_cnt_r[i] <= 2'h0;
            end
        end else begin
            data_prev_r <= data_nxt;
            for (int i = 0; i < mmio_pkg::NUM_PINS; i++) begin
                if (data_nxt[i] && !data_prev_r[i]) begin
                    kick_cnt_r[i] <= 2'(KICK - 1);
                end else if (kick_cnt_r[i] != 2'h0) begin
                    kick_cnt_r[i] <= kick_cnt_r[i] - 2'h1;
                end
            end
        end
    end

    // ==========================================================
    // Registered pin controls
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            pin_out        <= '0;
            pin_oe_n_out   <= '1;
            pin_pullup_out <= '0;
            pin_analog_out <= '0;
        end else begin
            pin_out        <= out_nxt;
            pin_oe_n_out   <= oe_n_nxt;
            pin_pullup_out <= pu_nxt;
            pin_analog_out <= ana_nxt;
        end
    end

    // ==========================================================
    // Pin sampling: three stages, accept when the last two agree.
    // A disabled digital buffer reads as zero only in mode three.
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
            level_r <= '0;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            for (int i = 0; i < mmio_pkg::NUM_PINS; i++) begin
                if (!din_en_nxt[i] && mode_of(modes, i) == mmio_pkg::MMIO_MODE_ANALOG) begin
                    level_r[i] <= 1'b0;
                end else if (sync2_r[i] == sync3_r[i]) begin
                    level_r[i] <= sync3_r[i];
                end
            end
        end
    end

    // ==========================================================
    // Outputs toward peripherals and the clock block
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            pin_level_out     <= '0;
            clock_control_out <= mmio_pkg::RST_CLK_CTRL;
            xtal_enable_out   <= 1'b0;
        end else begin
            pin_level_out     <= level_r;
            clock_control_out <= clk_ctrl_r;
            xtal_enable_out   <= xtal_on;
        end
    end

endmodule

// file: mmio_port_properties.sv
// Purpose: Assertions on the SFR bus and pin controls.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Pins claimed by the LED logic are exempt from pin checks.
`timescale 1ns/1ps
module mmio_port_chk (
    // Clock, reset and SFR bus
    input wire logic                core_clk_in,
    input wire logic                reset_in,
    input wire logic [7:0]          sfr_addr_in,
    input wire logic                sfr_wr_in,
    input wire logic                sfr_rd_in,
    input wire logic [7:0]          sfr_wdata_in,
    input wire logic [7:0]          sfr_rdata_out,
    input wire logic                sfr_hit_out,
    // Pins and clock block
    input wire mmio_pkg::mmio_led_t led_in,
    input wire logic [17:0]         pin_out,
    input wire logic [17:0]         pin_oe_n_out,
    input wire logic [17:0]         pin_pullup_out,
    input wire logic [17:0]         pin_analog_out,
    input wire logic [7:0]          clock_control_out,
    input wire logic                xtal_enable_out
);
    // ==========================================================
    // Core clock domain
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    a_read_hit: assert property (sfr_rd_in && sfr_addr_in == 8'h90 |=> sfr_hit_out)
        else $error("no hit after latch read");
    a_unmapped_zero: assert property (sfr_rd_in && sfr_addr_in == 8'h00 |=>
        sfr_rdata_out == 8'h00 && !sfr_hit_out) else $error("unmapped read answered");
    a_reset_values: assert property ($fell(reset_in) |-> pin_oe_n_out == 18'h3FFFF
        && clock_control_out == 8'h23 && !xtal_enable_out) else $error("bad reset state");
    // A driven or pulled converter pin skews the reading
    a_analog_quiet: assert property ((pin_analog_out & (~pin_oe_n_out | pin_pullup_out)
        & ~$past(led_in.active)) == 18'h00000) else $error("analog pin driven");
    a_pullup_not_low: assert property ((pin_pullup_out & ~pin_oe_n_out & ~pin_out
        & ~$past(led_in.active)) == 18'h00000) else $error("pull-up while sinking");
    a_clkctl_write: assert property (sfr_wr_in && sfr_addr_in == 8'hD8 |->
        ##2 clock_control_out == $past(sfr_wdata_in, 2)) else $error("clock control lost");
    a_xtal_select: assert property ($stable(clock_control_out[7:6]) [*2] |->
        xtal_enable_out == (|clock_control_out[7:6])) else $error("crystal enable wrong");
    a_xtal_pins_off: assert property (xtal_enable_out && $past(xtal_enable_out, 2)
        && ($past(led_in.active) & 18'h00300) == 18'h00000 |-> pin_oe_n_out[9:8] == 2'b11
        && pin_pullup_out[9:8] == 2'b00) else $error("crystal pins driven");
endmodule

bind mmio_port mmio_port_chk u_chk (.*);

// file: mmio_board.sv
// Purpose: Board model: resolves driver, pull-up and test drive.
// Assumes: Test drive wins over the port; contention is not modelled.
// Notes:   A pin left floating toggles, so a stale level never reads as valid.
`timescale 1ns/1ps
module mmio_board (
    // Port side and test drive
    input  wire logic        core_clk_in,
    input  wire logic [17:0] pin_out,
    input  wire logic [17:0] pin_oe_n_out,
    input  wire logic [17:0] pin_pullup_out,
    input  wire logic [17:0] ext_en,
    input  wire logic [17:0] ext_val,
    output logic      [17:0] pin_in
);
    logic [17:0] last_r = 18'h00000;   // Level on the last edge
    always_ff @(posedge core_clk_in) last_r <= pin_in;
    // Outside drive only on pins the bench left as inputs with latch high
    assign pin_in = ext_en & ext_val | ~ext_en & (~pin_oe_n_out & pin_out
        | pin_oe_n_out & (pin_pullup_out | ~last_r));
endmodule

// file: multi_mode_io_port_bench.sv
// Purpose: Self-checking bench for mmio_port with a board model on the pins.
// Assumes: 100 MHz clock; inputs change on the falling edge.
// Notes:   Strong-high count is checked against KICK.
`timescale 1ns/1ps
module multi_mode_io_port_bench;
    localparam int KICK = 2;
    logic core_clk_in = 1'b0, reset_in = 1'b1, sfr_wr_in = 1'b0, sfr_rd_in = 1'b0;
    logic sfr_rmw_in = 1'b0, sfr_hit_out, xtal_enable_out;
    logic [7:0] sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, sfr_rdata_out, clock_control_out;
    logic [7:0] pin_output_control_in = 8'h00, serial_periph_control_in = 8'h00;
    logic [2:0] pulse_output_enable_in = 3'h0;
    mmio_pkg::mmio_alt_t alt_in = 11'h018; // Transmitters idle high
    mmio_pkg::mmio_led_t led_in = '0;
    logic [17:0] pin_in, pin_out, pin_oe_n_out, pin_pullup_out, pin_analog_out, pin_level_out;
    logic [17:0] ext_en = 18'h00000, ext_val = 18'h00000;
    int n_mismatch = 0, checks_done = 0, kick_n = 0;
    always #5 core_clk_in = ~core_clk_in;
    mmio_port #(.KICK(KICK)) dut (.*);
    mmio_board board (.*);
    // Strong-high cycles on P3.0
    always @(negedge core_clk_in)
        if (!pin_oe_n_out[10] && pin_out[10])
            kick_n++;
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        if (n_mismatch == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask
    // Write, then let the pin plan settle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr_in = a;
        sfr_wdata_in = d;
        sfr_wr_in = 1'b1;
        cyc(1);
        sfr_wr_in = 1'b0;
        cyc(3);
    endtask
    // Read; answer and hit stand in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic m, input logic [7:0] msk,
        input logic [7:0] e, input logic h);
        sfr_addr_in = a;
        sfr_rmw_in = m;
        sfr_rd_in = 1'b1;
        cyc(1);
        sfr_rd_in = 1'b0;
        chk({9'h000, sfr_hit_out, sfr_rdata_out & msk}, {9'h000, h, e});
        cyc(1);
    endtask
    task automatic t_reset();
        logic [15:0] t [9] = '{16'h90FF, 16'hA003, 16'hA255, 16'hA355, 16'hB0FF, 16'hD823,
            16'h9305, 16'hA455, 16'hA515};
        chk(pin_oe_n_out, 18'h3FFFF);
        chk(pin_pullup_out, 18'h21C00);
        foreach (t[i]) rdc(t[i][15:8], 1'b1, 8'hFF, t[i][7:0], 1'b1);
        rdc(8'h00, 1'b0, 8'hFF, 8'h00, 1'b0);
    endtask
    task automatic t_modes();
        logic [1:0] m;
        logic d, oe;
        for (int i = 0; i < 8; i++) begin
            m = i[2:1];
            d = i[0];
            oe = m == 2'h3 || (!m[1] && d);
            wr(8'hA3, {4'h5, m, 2'h1});
            wr(8'h90, {2'h3, d, 5'h1F});
            chk({14'h0000, pin_oe_n_out[5], pin_pullup_out[5], pin_analog_out[5],
                pin_out[5] | pin_oe_n_out[5]}, {14'h0000, oe, m == 2'h0 && d, m == 2'h3,
                oe | d});
        end
    endtask
    task automatic t_rmw();
        wr(8'hA3, 8'h55);
        wr(8'h90, 8'hFF);
        ext_en[5] = 1'b1;
        cyc(8);
        rdc(8'h90, 1'b0, 8'h20, 8'h00, 1'b1);
        rdc(8'h90, 1'b1, 8'h20, 8'h20, 1'b1);
        ext_val[5] = 1'b1;
        wr(8'hA3, 8'h5D);
        cyc(8);
        rdc(8'h90, 1'b0, 8'h20, 8'h00, 1'b1);
        chk({17'h00000, pin_level_out[5]}, 18'h00000);
        ext_en[5] = 1'b0;
        wr(8'hA3, 8'h55);
    endtask
    task automatic t_kick();
        wr(8'hA4, 8'h54);
        wr(8'hB0, 8'hFE);
        kick_n = 0;
        wr(8'hB0, 8'hFF);
        cyc(4);
        chk(kick_n[17:0], 18'(KICK));
        chk({16'h0000, pin_oe_n_out[10], pin_pullup_out[10]}, 18'h00003);
        wr(8'hA4, 8'h55);
    endtask
    // Peripheral outputs ignore the latch
    task automatic t_alt();
        wr(8'hA5, 8'h1A);
        wr(8'hB0, 8'h00);
        pin_output_control_in = 8'h01;
        pulse_output_enable_in = 3'h1;
        serial_periph_control_in = 8'hC0;
        alt_in.t0_ovf = 1'b1;
        alt_in.mosi = 1'b1;
        cyc(3);
        chk({12'h000, pin_oe_n_out[15:14], pin_out[15:14], pin_oe_n_out[2], pin_out[2]},
            18'h0000C);
        alt_in.pwm[0] = 1'b1;
        cyc(3);
        chk({17'h00000, pin_oe_n_out[2]}, 18'h00001);
        alt_in = 11'h018;
        wr(8'hA5, 8'h15);
        wr(8'hB0, 8'hFF);
    endtask
    task automatic t_led();
        wr(8'h90, 8'hF7);
        led_in.active[3] = 1'b1;
        led_in.value[3] = 1'b1;
        led_in.drive[3] = 1'b1;
        cyc(3);
        chk({16'h0000, pin_oe_n_out[3], pin_out[3]}, 18'h00001);
        led_in = '0;
        wr(8'h90, 8'hFF);
    endtask
    task automatic t_xtal();
        wr(8'h93, 8'h00);
        for (int i = 0; i < 2; i++) begin
            wr(8'hD8, i[0] ? 8'h63 : 8'hA3);
            chk({9'h000, xtal_enable_out, clock_control_out}, {10'h001,
                i[0] ? 8'h63 : 8'hA3});
            chk({14'h0000, pin_oe_n_out[9:8], pin_pullup_out[9:8]}, 18'h0000C);
        end
        wr(8'hD8, 8'h23);
        chk({17'h00000, xtal_enable_out}, 18'h00000);
    endtask
    initial begin
        cyc(4);
        reset_in = 1'b0;
        cyc(2);
        t_reset();
        t_modes();
        t_rmw();
        t_kick();
        t_alt();
        t_led();
        t_xtal();
        end_of_test();
    end
    initial begin
        #100000;
        n_mismatch++;
        end_of_test();
    end
endmodule
